// File: rtl/two_wire_sync_serial_channel.v
// two-wire clock-synchronous 8-bit serial channel with its cpu registers
//
// What this block does
// (R1) eight-bit frames, most significant bit first
// (R2) trigger starts transfer only when enabled
// (R3) disabled: shifter stopped, counter cleared, pins port
// (R4) transmit mode: shift register write starts transfer
// (R5) receive-only mode: shift register read starts transfer
// (R6) clock select: pin, timer, div64, div128
// (R7) shift and drive data on falling edge
// (R8) sample data pin on rising edge
// (R9) stop after eighth bit, set done flag
// (R10) internal clock parked high between transfers
// (R11) write while disabled never starts transfer
// (R12) reset clears control and shift registers
// (R13) software avoids shift register during transfer
// (R14) software selects open drain, adds pull-ups
// (R15) software sets pin directions and latches
// (R16) port latches give static pin levels
// (R17) software loads all ones before receiving
// (R18) done flag requests interrupt until acknowledged
// (R19) control bits six to three read zero
`timescale 1ns/100ps
`include "serial_channel_map.vh"

module two_wire_sync_serial_channel
(
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	input  wire [15:0] cpu_addr_i,
	input  wire        cpu_wr_i,
	input  wire        cpu_rd_i,
	input  wire [7:0]  cpu_wdata_i,
	output reg  [7:0]  cpu_rdata_o,
	input  wire        eight_bit_timer_output_i,
	input  wire        clock_pin_direction_i,
	input  wire        data_pin_direction_i,
	input  wire        clock_pin_output_latch_i,
	input  wire        data_pin_output_latch_i,
	input  wire        clock_pin_open_drain_select_i,
	input  wire        data_pin_open_drain_select_i,
	input  wire        shift_clock_pin_i,
	output reg         shift_clock_pin_o,
	output reg         shift_clock_pin_oe_o,
	input  wire        data_pin_i,
	output reg         data_pin_o,
	output reg         data_pin_oe_o,
	output reg         transfer_busy_o,
	output reg         transfer_done_irq_o,
	input  wire        irq_ack_i
);

	reg  [7:0] serial_channel_control_reg;
	reg  [7:0] serial_shift_data_reg;
	reg  [3:0] bit_count_reg;
	reg        output_bit_latch_reg;
	reg        sck_prev_reg;
	wire       sck_internal;
	reg        sck_now;
	wire       channel_enable_flag;
	wire       receive_only_select;
	wire [1:0] clock_select;
	wire       ctrl_hit;
	wire       shift_hit;
	wire       start_write;
	wire       start_read;
	wire       sck_fall;
	wire       sck_rise;
	wire       last_rise;
	reg        clock_value;
	reg        data_value;

	assign channel_enable_flag = serial_channel_control_reg[`CTRL_ENABLE_BIT];
	assign receive_only_select = serial_channel_control_reg[`CTRL_MODE_BIT];
	assign clock_select        = {serial_channel_control_reg[`CTRL_SEL_HI_BIT],
	                              serial_channel_control_reg[`CTRL_SEL_LO_BIT]};
	assign ctrl_hit            = (cpu_addr_i == `CTRL_ADDR);
	assign shift_hit           = (cpu_addr_i == `SHIFT_ADDR);

	// (R2) start only when enabled and idle
	// (R11) a write while disabled only loads data
	assign start_write = cpu_wr_i & shift_hit & channel_enable_flag
	                     & ~receive_only_select & ~transfer_busy_o;
	assign start_read  = cpu_rd_i & shift_hit & channel_enable_flag
	                     & receive_only_select & ~transfer_busy_o;

	// (R10) divider restarts high at every new frame
	shift_clock_gen u_shift_clock_gen
	(
		.core_clk_i     (core_clk_i),
		.rst_n_i        (rst_n_i),
		.run_i          (transfer_busy_o),
		.clock_select_i (clock_select),
		.timer_level_i  (eight_bit_timer_output_i),
		.sck_o          (sck_internal)
	);

	// (R6) external pin or internal source
	always @*
	begin
		if (clock_select == `SEL_EXTERNAL)
			sck_now = shift_clock_pin_i;
		else
			sck_now = sck_internal;
	end

	assign sck_fall  = transfer_busy_o & sck_prev_reg & ~sck_now;
	assign sck_rise  = transfer_busy_o & ~sck_prev_reg & sck_now;
	assign last_rise = sck_rise & (bit_count_reg == `BITS_PER_FRAME - 4'h1);

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sck_prev_reg <= 1'b1;
		else
			sck_prev_reg <= sck_now;
	end

	// (R12) control register, reset to zero
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			serial_channel_control_reg <= `CTRL_RESET;
		else if (cpu_wr_i && ctrl_hit)
			// (R19) unused bits never store
			serial_channel_control_reg <= cpu_wdata_i & `CTRL_WRITE_MASK;
	end

	// shift register, bit counter, busy and output latch
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			serial_shift_data_reg <= `SHIFT_RESET;
			bit_count_reg         <= 4'h0;
			transfer_busy_o       <= 1'b0;
			output_bit_latch_reg  <= 1'b1;
		end
		else if (!channel_enable_flag)
		begin
			// (R3) stopped and counter held clear
			transfer_busy_o <= 1'b0;
			bit_count_reg   <= 4'h0;
			if (cpu_wr_i && shift_hit)
				serial_shift_data_reg <= cpu_wdata_i;
		end
		else if (!transfer_busy_o)
		begin
			bit_count_reg <= 4'h0;
			// (R4) write triggers in transmit mode
			// (R5) read triggers in receive-only mode
			if (start_write || start_read)
				transfer_busy_o <= 1'b1;
			// data may still be loaded in receive-only mode for the next frame
			if (cpu_wr_i && shift_hit)
				serial_shift_data_reg <= cpu_wdata_i;
		end
		else
		begin
			// (R13) accesses during a frame are left to software
			if (sck_fall)
			begin
				// (R1) msb leaves first
				// (R7) shift on the falling edge
				output_bit_latch_reg  <= serial_shift_data_reg[7];
				serial_shift_data_reg <= {serial_shift_data_reg[6:0],
				                          serial_shift_data_reg[7]};
			end
			if (sck_rise)
			begin
				// (R8) sample into the vacated bit
				serial_shift_data_reg[0] <= data_pin_i;
				bit_count_reg            <= bit_count_reg + 4'h1;
			end
			// (R9) self stop after the eighth bit
			if (last_rise)
				transfer_busy_o <= 1'b0;
		end
	end

	// (R18) sticky done request, set beats acknowledge
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			transfer_done_irq_o <= 1'b0;
		else if (last_rise)
			transfer_done_irq_o <= 1'b1;
		else if (irq_ack_i)
			transfer_done_irq_o <= 1'b0;
	end

	// registered read data, one cycle after the strobe
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cpu_rdata_o <= 8'h00;
		else if (cpu_rd_i && ctrl_hit)
			cpu_rdata_o <= serial_channel_control_reg;
		else if (cpu_rd_i && shift_hit)
			cpu_rdata_o <= serial_shift_data_reg;
		else if (cpu_rd_i)
			cpu_rdata_o <= 8'h00;
	end

	// pin levels: serial signal gated by the port latch
	always @*
	begin
		// (R16) latch level reaches the pin, ANDed with any serial signal
		clock_value = clock_pin_output_latch_i;
		data_value  = data_pin_output_latch_i;
		// (R3) disabled leaves both pins to the port
		if (channel_enable_flag && clock_select != `SEL_EXTERNAL)
			clock_value = clock_pin_output_latch_i & sck_internal;
		// receive-only keeps the data pin a plain port
		if (channel_enable_flag && !receive_only_select)
			data_value = data_pin_output_latch_i & output_bit_latch_reg;
	end

	// open drain only pulls low; a high comes from the external pull-up
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			shift_clock_pin_o    <= 1'b0;
			shift_clock_pin_oe_o <= 1'b0;
			data_pin_o           <= 1'b0;
			data_pin_oe_o        <= 1'b0;
		end
		else
		begin
			shift_clock_pin_o    <= clock_value & ~clock_pin_open_drain_select_i;
			shift_clock_pin_oe_o <= ~clock_pin_direction_i
			                        & (~clock_pin_open_drain_select_i | ~clock_value);
			data_pin_o           <= data_value & ~data_pin_open_drain_select_i;
			data_pin_oe_o        <= ~data_pin_direction_i
			                        & (~data_pin_open_drain_select_i | ~data_value);
		end
	end

endmodule

// File: rtl/serial_channel_map.vh
// addresses, field positions, reset values and clock figures of the serial channel
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH

`define CTRL_ADDR         16'hFFAA
`define SHIFT_ADDR        16'hFFAB
`define CTRL_RESET        8'h00
`define SHIFT_RESET       8'h00
`define CTRL_ENABLE_BIT   7
`define CTRL_MODE_BIT     2
`define CTRL_SEL_HI_BIT   1
`define CTRL_SEL_LO_BIT   0
`define CTRL_WRITE_MASK   8'h87
`define SEL_EXTERNAL      2'h0
`define SEL_TIMER         2'h1
`define SEL_DIV64         2'h2
`define SEL_DIV128        2'h3
`define DIV64_BIT         5
`define DIV128_BIT        6
`define BITS_PER_FRAME    4'h8
`define CORE_CLK_NS       100

`endif

// File: rtl/shift_clock_gen.v
// internal shift clock: timer level or core clock divided by 64 or 128, parked high when idle
`timescale 1ns/100ps
`include "serial_channel_map.vh"

module shift_clock_gen
(
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	input  wire       run_i,
	input  wire [1:0] clock_select_i,
	input  wire       timer_level_i,
	output reg        sck_o
);

	reg [6:0] div_reg;

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_reg <= 7'h00;
			sck_o   <= 1'b1;
		end
		else if (!run_i)
		begin
			// restart from zero so the first half period is high
			div_reg <= 7'h00;
			sck_o   <= 1'b1;
		end
		else
		begin
			div_reg <= div_reg + 7'h01;
			case (clock_select_i)
				`SEL_DIV64:  sck_o <= ~div_reg[`DIV64_BIT];
				`SEL_DIV128: sck_o <= ~div_reg[`DIV128_BIT];
				`SEL_TIMER:  sck_o <= timer_level_i;
				default:     sck_o <= 1'b1;
			endcase
		end
	end

endmodule

// File: testbench/serial_peripheral_model.sv
// serial peripheral on the shared open-drain data line
`timescale 1ns/100ps
module serial_peripheral_model
(
	input  wire       sck_i,
	input  wire       sd_i,
	input  wire [7:0] tx_i,
	input  wire       load_i,
	output reg        low_o = 1'b0,
	output reg  [7:0] rx_o
);
	reg [7:0] sh_reg;
	always @(negedge sck_i or posedge load_i)
		if (load_i)
		begin
			sh_reg <= tx_i;
			low_o <= 1'b0;
		end
		else
		begin
			low_o <= !sh_reg[7];
			// ones shifted in so the line is released after the frame
			sh_reg <= {sh_reg[6:0], 1'b1};
		end
	always @(posedge sck_i)
		rx_o <= {rx_o[6:0], sd_i};
endmodule

// File: testbench/serial_channel_monitor.sv
// port assertions of the serial channel
`timescale 1ns/100ps
`include "serial_channel_map.vh"
module serial_channel_monitor
(
	input wire        core_clk_i,
	input wire        rst_n_i,
	input wire [15:0] cpu_addr_i,
	input wire        cpu_wr_i,
	input wire        cpu_rd_i,
	input wire [7:0]  cpu_wdata_i,
	input wire [7:0]  cpu_rdata_o,
	input wire        clock_pin_output_latch_i,
	input wire        shift_clock_pin_o,
	input wire        shift_clock_pin_oe_o,
	input wire        transfer_busy_o,
	input wire        transfer_done_irq_o,
	input wire        irq_ack_i
);
	reg  [7:0] ctrl_reg;
	wire       sh = cpu_addr_i == `SHIFT_ADDR;
	wire       trig = ctrl_reg[7] && sh && (ctrl_reg[2] ? cpu_rd_i : cpu_wr_i);
	always @(posedge core_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			ctrl_reg <= 8'h00;
		else if (cpu_wr_i && cpu_addr_i == `CTRL_ADDR)
			ctrl_reg <= cpu_wdata_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_disable_stops: assert property (!ctrl_reg[7] |=> !transfer_busy_o)
		else $error("busy while disabled");
	a_write_starts: assert property (trig && !ctrl_reg[2] && !transfer_busy_o |=> transfer_busy_o)
		else $error("write trigger ignored");
	a_read_starts: assert property (trig && ctrl_reg[2] && !transfer_busy_o |=> transfer_busy_o)
		else $error("read trigger ignored");
	a_start_needs_trigger: assert property ($rose(transfer_busy_o) |-> $past(trig))
		else $error("frame without trigger");
	a_done_sets_flag: assert property ($fell(transfer_busy_o) && ctrl_reg[7] |-> transfer_done_irq_o)
		else $error("no done flag");
	a_flag_sticky: assert property (transfer_done_irq_o && !irq_ack_i |=> transfer_done_irq_o)
		else $error("flag lost");
	a_ctrl_readback: assert property (cpu_rd_i && cpu_addr_i == `CTRL_ADDR |=>
		cpu_rdata_o == (ctrl_reg & `CTRL_WRITE_MASK))
		else $error("control readback");
	// pins lag the fall of busy by two cycles, hence four idle cycles first
	a_clock_parked: assert property (
		(!transfer_busy_o && ctrl_reg[1] && clock_pin_output_latch_i)[*4]
		|-> !(shift_clock_pin_oe_o && !shift_clock_pin_o))
		else $error("idle clock low");
endmodule
bind two_wire_sync_serial_channel serial_channel_monitor u_monitor (.core_clk_i, .rst_n_i,
	.cpu_addr_i, .cpu_wr_i, .cpu_rd_i, .cpu_wdata_i, .cpu_rdata_o, .clock_pin_output_latch_i,
	.shift_clock_pin_o, .shift_clock_pin_oe_o, .transfer_busy_o, .transfer_done_irq_o, .irq_ack_i);

// File: testbench/testbench.sv
// register tasks and transfer scenarios for the serial channel
`timescale 1ns/100ps
`include "serial_channel_map.vh"
module testbench;
	reg        core_clk_i = 1'b0;
	reg        rst_n_i = 1'b0;
	reg [15:0] cpu_addr_i = 16'h0000;
	reg        cpu_wr_i = 1'b0;
	reg        cpu_rd_i = 1'b0;
	reg [7:0]  cpu_wdata_i = 8'h00;
	reg        irq_ack_i = 1'b0;
	reg        data_pin_output_latch_i = 1'b1;
	reg        clock_pin_output_latch_i = 1'b1;
	reg        tog = 1'b1;
	reg        run = 1'b0;
	reg        ext = 1'b0;
	reg        load = 1'b0;
	reg [7:0]  ptx = 8'hFF;
	reg [4:0]  cnt = 5'h00;
	reg [31:0] dt = 32'hFF4EFFB1;
	reg [31:0] pt = 32'h71FF2DFF;
	wire [7:0] cpu_rdata_o;
	wire [7:0] prx;
	wire       shift_clock_pin_o, shift_clock_pin_oe_o, data_pin_o, data_pin_oe_o, plow;
	wire       transfer_busy_o, transfer_done_irq_o;
	// pull-ups on both open-drain lines
	wire       sck_w = !(shift_clock_pin_oe_o && !shift_clock_pin_o) && (ext ? tog : 1'b1);
	wire       sd_w = !(data_pin_oe_o && !data_pin_o) && !plow;
	integer    fails = 0;
	integer    samples_checked = 0;
	integer    cyc;
	integer    s;
	two_wire_sync_serial_channel DUT (.core_clk_i, .rst_n_i, .cpu_addr_i, .cpu_wr_i, .cpu_rd_i,
		.cpu_wdata_i, .cpu_rdata_o, .eight_bit_timer_output_i(tog), .clock_pin_direction_i(1'b0),
		.data_pin_direction_i(1'b0), .clock_pin_output_latch_i, .data_pin_output_latch_i,
		.clock_pin_open_drain_select_i(1'b1), .data_pin_open_drain_select_i(1'b1),
		.shift_clock_pin_i(sck_w), .shift_clock_pin_o, .shift_clock_pin_oe_o, .data_pin_i(sd_w),
		.data_pin_o, .data_pin_oe_o, .transfer_busy_o, .transfer_done_irq_o, .irq_ack_i);
	serial_peripheral_model u_peer (.sck_i(sck_w), .sd_i(sd_w), .tx_i(ptx), .load_i(load),
		.low_o(plow), .rx_o(prx));
	always #50 core_clk_i = ~core_clk_i;
	// external and timer clock: period 40, stands high between frames
	always @(posedge core_clk_i)
		cnt <= (run && cnt != 5'h13) ? cnt + 5'h01 : 5'h00;
	always @(posedge core_clk_i)
		if (run && cnt == 5'h13)
			tog <= ~tog;
	task chk(input string n, input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp)
			begin
				fails = fails + 1;
				$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
			end
		end
	endtask
	task wr_reg(input [15:0] a, input [7:0] v);
		begin
			@(posedge core_clk_i);
			cpu_addr_i <= a;
			cpu_wdata_i <= v;
			cpu_wr_i <= 1'b1;
			@(posedge core_clk_i);
			cpu_wr_i <= 1'b0;
		end
	endtask
	task rd_reg(input [15:0] a, input [7:0] e);
		begin
			@(posedge core_clk_i);
			cpu_addr_i <= a;
			cpu_rd_i <= 1'b1;
			@(posedge core_clk_i);
			cpu_rd_i <= 1'b0;
			@(negedge core_clk_i);
			chk("rdata", cpu_rdata_o, e);
		end
	endtask
	task load_peer(input [7:0] v);
		begin
			@(posedge core_clk_i);
			ptx <= v;
			@(posedge core_clk_i);
			load <= 1'b1;
			@(posedge core_clk_i);
			load <= 1'b0;
		end
	endtask
	task xfer(input [7:0] e, input integer per);
		begin
			for (cyc = 0; cyc < 3000 && transfer_done_irq_o !== 1'b1; cyc = cyc + 1)
				@(negedge core_clk_i);
			run <= 1'b0;
			chk("frame_len", cyc / per, 8'h08);
			chk("peer_rx", prx, e);
			rd_reg(`SHIFT_ADDR, e);
			@(posedge core_clk_i);
			irq_ack_i <= 1'b1;
			@(posedge core_clk_i);
			irq_ack_i <= 1'b0;
			@(negedge core_clk_i);
			chk("done", {7'h00, transfer_done_irq_o}, 8'h00);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// about 3500 cycles expected, so 10000 cycles means a hang
	initial
	begin
		#1000000;
		fails = fails + 1;
		final_report;
	end
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd_reg(`CTRL_ADDR, `CTRL_RESET);
		rd_reg(`SHIFT_ADDR, `SHIFT_RESET);
		wr_reg(`CTRL_ADDR, 8'hFB);
		rd_reg(`CTRL_ADDR, 8'h83);
		rd_reg(16'h1234, 8'h00);
		wr_reg(`CTRL_ADDR, 8'h00);
		wr_reg(`SHIFT_ADDR, 8'h96);
		wr_reg(`CTRL_ADDR, 8'h82);
		repeat (20) @(negedge core_clk_i);
		chk("busy", {7'h00, transfer_busy_o}, 8'h00);
		for (s = 0; s < 4; s = s + 1)
		begin
			ext <= (s == 0);
			wr_reg(`CTRL_ADDR, {6'h20, s[1:0]});
			load_peer(pt[8*s +: 8]);
			wr_reg(`SHIFT_ADDR, dt[8*s +: 8]);
			run <= (s < 2);
			xfer(dt[8*s +: 8] & pt[8*s +: 8], (s < 2) ? 40 : 16 << s);
		end
		wr_reg(`CTRL_ADDR, 8'h86);
		load_peer(8'h5A);
		wr_reg(`SHIFT_ADDR, 8'hFF);
		rd_reg(`SHIFT_ADDR, 8'hFF);
		xfer(8'h5A, 64);
		chk("rd_restart", {7'h00, transfer_busy_o}, 8'h01);
		// stop the read-started frame before new data
		wr_reg(`CTRL_ADDR, 8'h00);
		wr_reg(`CTRL_ADDR, 8'h82);
		wr_reg(`SHIFT_ADDR, 8'h96);
		repeat (100) @(posedge core_clk_i);
		wr_reg(`CTRL_ADDR, 8'h00);
		repeat (600) @(negedge core_clk_i);
		chk("abort", {6'h00, transfer_busy_o, transfer_done_irq_o}, 8'h00);
		chk("static_high", {6'h00, sck_w, sd_w}, 8'h03);
		@(posedge core_clk_i);
		data_pin_output_latch_i <= 1'b0;
		clock_pin_output_latch_i <= 1'b0;
		repeat (4) @(negedge core_clk_i);
		chk("static_low", {6'h00, sck_w, sd_w}, 8'h00);
		final_report;
	end
endmodule
